// ===== rtl/pin_channel_pkg.sv
// Contract
// RQ1 - Twelve long registers retune pins during testing
// RQ2 - Two switchable care-mask and direction pairs
// RQ3 - Per-pin choice of four reference pairs
// RQ4 - Per-pin choice of two strobe lines
// RQ5 - Per-pin return or non-return to zero
// RQ6 - Fail store captures per-pin compare results
// RQ7 - Flip mask inverts selected pins' pattern data
// RQ8 - Three registers choose one of six generators
// RQ9 - One utility relay bit per pin
// RQ10 - Pattern port writes go into local memory
// RQ11 - One local pattern channel per pin
// RQ12 - Pattern loads allowed while testing runs
// RQ13 - Major and minor loops with start/stop/count
// RQ14 - Pins act as drive, compare, bias, load
// RQ15 - Drive every period; strobe per timing generator
// RQ16 - Periods sustain up to ten million per second
// RQ17 - External sync lets the device pace periods
// RQ18 - Strobed level compared with expected pattern level
// RQ19 - Don't-care pins never record a mismatch
// RQ20 - Stop on failure or sequence end
package pin_channel_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_MASK0 = 8'h00;
	localparam logic [7:0] OFS_DIR0 = 8'h04;
	localparam logic [7:0] OFS_MASK1 = 8'h08;
	localparam logic [7:0] OFS_DIR1 = 8'h0C;
	localparam logic [7:0] OFS_LEVEL = 8'h10;
	localparam logic [7:0] OFS_STROBE = 8'h14;
	localparam logic [7:0] OFS_FORMAT = 8'h18;
	localparam logic [7:0] OFS_FAIL = 8'h1C;
	localparam logic [7:0] OFS_FLIP = 8'h20;
	localparam logic [7:0] OFS_TG0 = 8'h24;
	localparam logic [7:0] OFS_TG1 = 8'h28;
	localparam logic [7:0] OFS_TG2 = 8'h2C;
	localparam logic [7:0] OFS_RELAY = 8'h30;
	localparam logic [7:0] OFS_PATTERN = 8'h34;
	localparam logic [7:0] OFS_LOAD_ADDR = 8'h38;
	localparam logic [7:0] OFS_CTRL = 8'h3C;
	localparam logic [7:0] OFS_MAJ_START = 8'h40;
	localparam logic [7:0] OFS_MAJ_STOP = 8'h44;
	localparam logic [7:0] OFS_MAJ_COUNT = 8'h48;
	localparam logic [7:0] OFS_MIN_START = 8'h4C;
	localparam logic [7:0] OFS_MIN_STOP = 8'h50;
	localparam logic [7:0] OFS_MIN_COUNT = 8'h54;
	localparam logic [7:0] OFS_STATUS = 8'h58;
	localparam logic [7:0] OFS_PERIOD = 8'h5C;
	localparam int CTRL_START = 0;
	localparam int CTRL_STOP = 1;
	localparam int CTRL_PAIR = 2;
	localparam int CTRL_EXT = 3;
	localparam int CLK_PERIOD_NS = 20;
	localparam int TEST_PERIOD_MIN_NS = 100;
	localparam int PERIOD_MIN_CYC = (TEST_PERIOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [15:0] PERIOD_RST = 16'h0005;
	localparam int NUM_TG = 6;
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE, ST_FAIL} seq_state_t;
endpackage

// ===== rtl/tester_pin_channel_control.sv
`timescale 1ns/10ps
`default_nettype none
module tester_pin_channel_control
#(
	parameter int NPINS = 16,
	parameter int DEPTH = 64
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Register port
	input wire logic [pin_channel_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [pin_channel_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [pin_channel_pkg::DATA_W-1:0] reg_rdata,
	// Timing generator pulses and external sync
	input wire logic [pin_channel_pkg::NUM_TG-1:0] tg_pulse,
	input wire logic dut_sync,
	// Pin electronics
	input wire logic [NPINS-1:0] pin_sense,
	output logic [NPINS-1:0] pin_drive,
	output logic [NPINS-1:0] pin_drive_en,
	output logic [2*NPINS-1:0] level_pair_sel,
	output logic [NPINS-1:0] strobe_line_choice,
	output logic [NPINS-1:0] drive_format_bits,
	output logic [NPINS-1:0] relay_on,
	output logic [3*NPINS-1:0] timing_gen_choice,
	// Sequencer status
	output logic test_running,
	output logic test_failed,
	output logic test_done
);
	localparam int AW = $clog2(DEPTH);
	// Six generators numbered from one; codes 0 and 7 select none
	function automatic logic tg_fire(input logic [2:0] code, input logic [pin_channel_pkg::NUM_TG-1:0] p);
		return (code >= 3'h1 && code <= 3'h6) ? p[code - 3'h1] : 1'b0;
	endfunction
	logic [NPINS-1:0] mask_r [2];
	logic [NPINS-1:0] mask_nxt [2];
	logic [NPINS-1:0] dir_r [2];
	logic [NPINS-1:0] dir_nxt [2];
	logic [2*NPINS-1:0] level_r, level_nxt;
	logic [NPINS-1:0] strobe_r, strobe_nxt, format_r, format_nxt, fail_r, fail_nxt;
	logic [NPINS-1:0] flip_r, flip_nxt, relay_r, relay_nxt;
	logic [NPINS-1:0] tg0_r, tg0_nxt, tg1_r, tg1_nxt, tg2_r, tg2_nxt;
	logic [AW-1:0] load_addr_r, load_addr_nxt;
	logic pair_r, pair_nxt, ext_r, ext_nxt;
	logic [AW-1:0] maj_start_r, maj_start_nxt, maj_stop_r, maj_stop_nxt;
	logic [AW-1:0] min_start_r, min_start_nxt, min_stop_r, min_stop_nxt;
	logic [15:0] maj_count_r, maj_count_nxt, min_count_r, min_count_nxt;
	logic [15:0] maj_left_r, maj_left_nxt, min_left_r, min_left_nxt;
	logic [15:0] period_r, period_nxt, cnt_r, cnt_nxt;
	logic [AW-1:0] seq_addr_r, seq_addr_nxt;
	pin_channel_pkg::seq_state_t state_r, state_nxt;
	logic miss_any_r, miss_any_nxt;
	logic [NPINS-1:0] exp_r, exp_nxt;
	logic [NPINS-1:0] drive_r, drive_nxt, drive_en_r, drive_en_nxt;
	logic [pin_channel_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
	logic [NPINS-1:0] s1_r, s2_r, s3_r, sense_r, sense_nxt;
	logic y1_r, y2_r, y3_r, sync_r, sync_nxt;
	logic [NPINS-1:0] pat_word, miss;
	logic wr_pattern, tick;
	logic running_r, failed_r, done_r;

	assign wr_pattern = reg_wr && reg_addr == pin_channel_pkg::OFS_PATTERN; // RQ10

	// One storage channel per pin, loadable at any time
	genvar p;
	generate
		for (p = 0; p < NPINS; p++)
		begin : g_pin
			logic [DEPTH-1:0] chan_r, chan_nxt;
			logic [2:0] code;
			always_comb
			begin
				chan_nxt = chan_r;
				if (wr_pattern)
					chan_nxt[load_addr_r] = reg_wdata[p]; // RQ11 RQ12
			end
			always_ff @(posedge clk or negedge rst_b)
			begin
				if (!rst_b)
					chan_r <= '0;
				else
					chan_r <= chan_nxt;
			end
			assign pat_word[p] = chan_r[seq_addr_r];
			assign code = {tg2_r[p], tg1_r[p], tg0_r[p]}; // RQ8
			// Only care, compare-direction pins strobed by their own generator
			assign miss[p] = state_r == pin_channel_pkg::ST_RUN && tg_fire(code, tg_pulse)
				&& mask_r[pair_r][p] && !dir_r[pair_r][p] && (sense_r[p] != exp_r[p]); // RQ15 RQ18 RQ19
		end
	endgenerate

	// Pin and sync inputs: change accepted once stages two and three agree
	always_comb
	begin
		sense_nxt = sense_r;
		for (int i = 0; i < NPINS; i++)
			if (s2_r[i] == s3_r[i])
				sense_nxt[i] = s3_r[i];
		sync_nxt = (y2_r == y3_r) ? y3_r : sync_r;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			{y1_r, s1_r} <= '0;
			{y2_r, s2_r} <= '0;
			{y3_r, s3_r} <= '0;
			{sync_r, sense_r} <= '0;
		end
		else
		begin
			{y1_r, s1_r} <= {dut_sync, pin_sense};
			{y2_r, s2_r} <= {y1_r, s1_r};
			{y3_r, s3_r} <= {y2_r, s2_r};
			{sync_r, sense_r} <= {sync_nxt, sense_nxt};
		end
	end
	// Period start: internal divider, or device's accepted rising sync edge
	assign tick = ext_r ? (sync_nxt && !sync_r) : (cnt_r == 16'h0000); // RQ16 RQ17
	always_comb
	begin
		mask_nxt = mask_r;
		dir_nxt = dir_r;
		level_nxt = level_r;
		strobe_nxt = strobe_r;
		format_nxt = format_r;
		flip_nxt = flip_r;
		relay_nxt = relay_r;
		tg0_nxt = tg0_r;
		tg1_nxt = tg1_r;
		tg2_nxt = tg2_r;
		load_addr_nxt = load_addr_r;
		pair_nxt = pair_r;
		ext_nxt = ext_r;
		maj_start_nxt = maj_start_r;
		maj_stop_nxt = maj_stop_r;
		maj_count_nxt = maj_count_r;
		min_start_nxt = min_start_r;
		min_stop_nxt = min_stop_r;
		min_count_nxt = min_count_r;
		period_nxt = period_r;
		fail_nxt = fail_r;
		state_nxt = state_r;
		seq_addr_nxt = seq_addr_r;
		maj_left_nxt = maj_left_r;
		min_left_nxt = min_left_r;
		miss_any_nxt = miss_any_r;
		exp_nxt = exp_r;
		drive_nxt = drive_r;
		drive_en_nxt = drive_en_r;
		cnt_nxt = (cnt_r == 16'h0000) ? period_r - 16'h0001 : cnt_r - 16'h0001;
		rdata_nxt = '0;
		// Register writes are taken in any state so pins retune mid-test
		if (reg_wr)
		begin
			unique case (reg_addr)
				pin_channel_pkg::OFS_MASK0: mask_nxt[0] = reg_wdata[NPINS-1:0]; // RQ1 RQ2
				pin_channel_pkg::OFS_DIR0: dir_nxt[0] = reg_wdata[NPINS-1:0]; // RQ2
				pin_channel_pkg::OFS_MASK1: mask_nxt[1] = reg_wdata[NPINS-1:0]; // RQ2
				pin_channel_pkg::OFS_DIR1: dir_nxt[1] = reg_wdata[NPINS-1:0]; // RQ2
				pin_channel_pkg::OFS_LEVEL: level_nxt = reg_wdata[2*NPINS-1:0]; // RQ3
				pin_channel_pkg::OFS_STROBE: strobe_nxt = reg_wdata[NPINS-1:0]; // RQ4
				pin_channel_pkg::OFS_FORMAT: format_nxt = reg_wdata[NPINS-1:0]; // RQ5
				pin_channel_pkg::OFS_FAIL: fail_nxt = fail_r & ~reg_wdata[NPINS-1:0];
				pin_channel_pkg::OFS_FLIP: flip_nxt = reg_wdata[NPINS-1:0]; // RQ7
				pin_channel_pkg::OFS_TG0: tg0_nxt = reg_wdata[NPINS-1:0]; // RQ8
				pin_channel_pkg::OFS_TG1: tg1_nxt = reg_wdata[NPINS-1:0]; // RQ8
				pin_channel_pkg::OFS_TG2: tg2_nxt = reg_wdata[NPINS-1:0]; // RQ8
				pin_channel_pkg::OFS_RELAY: relay_nxt = reg_wdata[NPINS-1:0]; // RQ9 RQ14
				pin_channel_pkg::OFS_PATTERN: load_addr_nxt = load_addr_r + 1'b1; // RQ10
				pin_channel_pkg::OFS_LOAD_ADDR: load_addr_nxt = reg_wdata[AW-1:0];
				pin_channel_pkg::OFS_CTRL:
				begin
					pair_nxt = reg_wdata[pin_channel_pkg::CTRL_PAIR]; // RQ2
					ext_nxt = reg_wdata[pin_channel_pkg::CTRL_EXT]; // RQ17
				end
				pin_channel_pkg::OFS_MAJ_START: maj_start_nxt = reg_wdata[AW-1:0]; // RQ13
				pin_channel_pkg::OFS_MAJ_STOP: maj_stop_nxt = reg_wdata[AW-1:0]; // RQ13
				pin_channel_pkg::OFS_MAJ_COUNT: maj_count_nxt = reg_wdata[15:0]; // RQ13
				pin_channel_pkg::OFS_MIN_START: min_start_nxt = reg_wdata[AW-1:0]; // RQ13
				pin_channel_pkg::OFS_MIN_STOP: min_stop_nxt = reg_wdata[AW-1:0]; // RQ13
				pin_channel_pkg::OFS_MIN_COUNT: min_count_nxt = reg_wdata[15:0]; // RQ13
				// Clamped so the period never falls below the fastest rate
				pin_channel_pkg::OFS_PERIOD: period_nxt = (reg_wdata[15:0] < 16'(pin_channel_pkg::PERIOD_MIN_CYC))
					? 16'(pin_channel_pkg::PERIOD_MIN_CYC) : reg_wdata[15:0]; // RQ16
				default: ;
			endcase
		end
		// Mismatch sets win over a same-cycle software clear
		fail_nxt = fail_nxt | miss; // RQ6
		if (|miss)
			miss_any_nxt = 1'b1;
		unique case (state_r)
			pin_channel_pkg::ST_IDLE, pin_channel_pkg::ST_DONE, pin_channel_pkg::ST_FAIL:
			begin
				if (reg_wr && reg_addr == pin_channel_pkg::OFS_CTRL && reg_wdata[pin_channel_pkg::CTRL_START])
				begin
					state_nxt = pin_channel_pkg::ST_RUN;
					seq_addr_nxt = maj_start_r;
					maj_left_nxt = maj_count_r;
					min_left_nxt = min_count_r;
					miss_any_nxt = 1'b0;
					exp_nxt = '0;
					cnt_nxt = 16'h0000;
				end
			end
			pin_channel_pkg::ST_RUN:
			begin
				if (reg_wr && reg_addr == pin_channel_pkg::OFS_CTRL && reg_wdata[pin_channel_pkg::CTRL_STOP])
					state_nxt = pin_channel_pkg::ST_IDLE;
				else if (tick)
				begin
					if (miss_any_r || |miss)
						state_nxt = pin_channel_pkg::ST_FAIL; // RQ20
					else
					begin
						// Apply this period's word to all drive pins at once
						exp_nxt = pat_word ^ flip_r; // RQ7 RQ18
						drive_nxt = pat_word ^ flip_r; // RQ15
						drive_en_nxt = dir_r[pair_r]; // RQ14 RQ15
						miss_any_nxt = 1'b0;
						if (seq_addr_r == min_stop_r && min_left_r != 16'h0000)
						begin
							seq_addr_nxt = min_start_r; // RQ13
							min_left_nxt = min_left_r - 16'h0001;
						end
						else if (seq_addr_r == maj_stop_r)
						begin
							if (maj_left_r != 16'h0000)
							begin
								seq_addr_nxt = maj_start_r; // RQ13
								maj_left_nxt = maj_left_r - 16'h0001;
								min_left_nxt = min_count_r;
							end
							else
								state_nxt = pin_channel_pkg::ST_DONE; // RQ20
						end
						else
							seq_addr_nxt = seq_addr_r + 1'b1;
					end
				end
			end
		endcase
		if (reg_rd)
		begin
			unique case (reg_addr)
				pin_channel_pkg::OFS_MASK0: rdata_nxt[NPINS-1:0] = mask_r[0];
				pin_channel_pkg::OFS_DIR0: rdata_nxt[NPINS-1:0] = dir_r[0];
				pin_channel_pkg::OFS_MASK1: rdata_nxt[NPINS-1:0] = mask_r[1];
				pin_channel_pkg::OFS_DIR1: rdata_nxt[NPINS-1:0] = dir_r[1];
				pin_channel_pkg::OFS_LEVEL: rdata_nxt[2*NPINS-1:0] = level_r;
				pin_channel_pkg::OFS_STROBE: rdata_nxt[NPINS-1:0] = strobe_r;
				pin_channel_pkg::OFS_FORMAT: rdata_nxt[NPINS-1:0] = format_r;
				pin_channel_pkg::OFS_FAIL: rdata_nxt[NPINS-1:0] = fail_r; // RQ6
				pin_channel_pkg::OFS_FLIP: rdata_nxt[NPINS-1:0] = flip_r;
				pin_channel_pkg::OFS_TG0: rdata_nxt[NPINS-1:0] = tg0_r;
				pin_channel_pkg::OFS_TG1: rdata_nxt[NPINS-1:0] = tg1_r;
				pin_channel_pkg::OFS_TG2: rdata_nxt[NPINS-1:0] = tg2_r;
				pin_channel_pkg::OFS_RELAY: rdata_nxt[NPINS-1:0] = relay_r;
				pin_channel_pkg::OFS_LOAD_ADDR: rdata_nxt[AW-1:0] = load_addr_r;
				pin_channel_pkg::OFS_CTRL: rdata_nxt[3:2] = {ext_r, pair_r};
				pin_channel_pkg::OFS_MAJ_START: rdata_nxt[AW-1:0] = maj_start_r;
				pin_channel_pkg::OFS_MAJ_STOP: rdata_nxt[AW-1:0] = maj_stop_r;
				pin_channel_pkg::OFS_MAJ_COUNT: rdata_nxt[15:0] = maj_count_r;
				pin_channel_pkg::OFS_MIN_START: rdata_nxt[AW-1:0] = min_start_r;
				pin_channel_pkg::OFS_MIN_STOP: rdata_nxt[AW-1:0] = min_stop_r;
				pin_channel_pkg::OFS_MIN_COUNT: rdata_nxt[15:0] = min_count_r;
				pin_channel_pkg::OFS_STATUS: rdata_nxt = {state_r, 14'h0000, 16'(seq_addr_r)};
				pin_channel_pkg::OFS_PERIOD: rdata_nxt[15:0] = period_r;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mask_r <= '{default: '0};
			dir_r <= '{default: '0};
			level_r <= '0;
			strobe_r <= '0;
			format_r <= '0;
			fail_r <= '0;
			flip_r <= '0;
			relay_r <= '0;
			tg0_r <= '0;
			tg1_r <= '0;
			tg2_r <= '0;
			load_addr_r <= '0;
			pair_r <= 1'b0;
			ext_r <= 1'b0;
			maj_start_r <= '0;
			maj_stop_r <= '0;
			maj_count_r <= '0;
			min_start_r <= '0;
			min_stop_r <= '0;
			min_count_r <= '0;
			period_r <= pin_channel_pkg::PERIOD_RST;
			cnt_r <= '0;
			state_r <= pin_channel_pkg::ST_IDLE;
			seq_addr_r <= '0;
			maj_left_r <= '0;
			min_left_r <= '0;
			miss_any_r <= 1'b0;
			exp_r <= '0;
			drive_r <= '0;
			drive_en_r <= '0;
			rdata_r <= '0;
			{running_r, failed_r, done_r} <= 3'h0;
		end
		else
		begin
			mask_r <= mask_nxt;
			dir_r <= dir_nxt;
			level_r <= level_nxt;
			strobe_r <= strobe_nxt;
			format_r <= format_nxt;
			fail_r <= fail_nxt;
			flip_r <= flip_nxt;
			relay_r <= relay_nxt;
			tg0_r <= tg0_nxt;
			tg1_r <= tg1_nxt;
			tg2_r <= tg2_nxt;
			load_addr_r <= load_addr_nxt;
			pair_r <= pair_nxt;
			ext_r <= ext_nxt;
			maj_start_r <= maj_start_nxt;
			maj_stop_r <= maj_stop_nxt;
			maj_count_r <= maj_count_nxt;
			min_start_r <= min_start_nxt;
			min_stop_r <= min_stop_nxt;
			min_count_r <= min_count_nxt;
			period_r <= period_nxt;
			cnt_r <= cnt_nxt;
			state_r <= state_nxt;
			seq_addr_r <= seq_addr_nxt;
			maj_left_r <= maj_left_nxt;
			min_left_r <= min_left_nxt;
			miss_any_r <= miss_any_nxt;
			exp_r <= exp_nxt;
			drive_r <= drive_nxt;
			drive_en_r <= drive_en_nxt;
			rdata_r <= rdata_nxt;
			// Status kept in its own flops so the outputs carry no decode glitches
			running_r <= state_nxt == pin_channel_pkg::ST_RUN;
			failed_r <= state_nxt == pin_channel_pkg::ST_FAIL;
			done_r <= state_nxt == pin_channel_pkg::ST_DONE;
		end
	end

	assign reg_rdata = rdata_r;
	assign pin_drive = drive_r;
	assign pin_drive_en = drive_en_r;
	assign level_pair_sel = level_r; // RQ3
	assign strobe_line_choice = strobe_r; // RQ4
	assign drive_format_bits = format_r; // RQ5
	assign relay_on = relay_r; // RQ9
	assign timing_gen_choice = {tg2_r, tg1_r, tg0_r};
	assign test_running = running_r;
	assign test_failed = failed_r;
	assign test_done = done_r;
endmodule
`default_nettype wire

// ===== verification/pin_channel_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module pin_channel_monitor
#(
	parameter int NPINS = 16
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Register port
	input wire logic [pin_channel_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [pin_channel_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [pin_channel_pkg::DATA_W-1:0] reg_rdata,
	// Pin side
	input wire logic [NPINS-1:0] pin_drive,
	input wire logic [2*NPINS-1:0] level_pair_sel,
	input wire logic [NPINS-1:0] strobe_line_choice,
	input wire logic [NPINS-1:0] drive_format_bits,
	input wire logic [NPINS-1:0] relay_on,
	// Sequencer status
	input wire logic test_running,
	input wire logic test_failed,
	input wire logic test_done
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	// Strobe and address are passed in so the sampled values are used
	function automatic logic hit(input logic w, input logic [7:0] ad, input logic [7:0] a);
		return w && ad == a;
	endfunction
	AST_RDATA_IDLE:
		assert property (!reg_rd |=> reg_rdata == '0)
		else $error("read data outside its slot");
	AST_PATTERN_READ:
		assert property (reg_rd && reg_addr == pin_channel_pkg::OFS_PATTERN |=> reg_rdata == '0)
		else $error("pattern port returned data");
	AST_LEVEL:
		assert property (hit(reg_wr, reg_addr, pin_channel_pkg::OFS_LEVEL)
			|=> level_pair_sel == $past(reg_wdata[2*NPINS-1:0]))
		else $error("level pair output wrong");
	AST_STROBE:
		assert property (hit(reg_wr, reg_addr, pin_channel_pkg::OFS_STROBE)
			|=> strobe_line_choice == $past(reg_wdata[NPINS-1:0]))
		else $error("strobe line output wrong");
	AST_FORMAT:
		assert property (hit(reg_wr, reg_addr, pin_channel_pkg::OFS_FORMAT)
			|=> drive_format_bits == $past(reg_wdata[NPINS-1:0]))
		else $error("drive format output wrong");
	AST_RELAY:
		assert property (hit(reg_wr, reg_addr, pin_channel_pkg::OFS_RELAY)
			|=> relay_on == $past(reg_wdata[NPINS-1:0]))
		else $error("relay output wrong");
	AST_ENDSTATE:
		assert property ((test_done || test_failed) && !hit(reg_wr, reg_addr, pin_channel_pkg::OFS_CTRL)
			|=> $stable({test_done, test_failed}))
		else $error("end state left without a start");
	AST_STOP:
		assert property (test_running && hit(reg_wr, reg_addr, pin_channel_pkg::OFS_CTRL) && reg_wdata[1:0] == 2'h2
			|=> !test_running && !test_done && !test_failed)
		else $error("stop did not return to idle");
	// Register writes are excluded, though no write reaches the drive while idle; drive_r changes only on a tick in ST_RUN
	AST_DRIVE_HOLD:
		assert property (!test_running && !reg_wr ##1 !test_running |-> $stable(pin_drive))
		else $error("drive changed while idle");
endmodule
`default_nettype wire

// ===== verification/pin_device_model.sv
`timescale 1ns/10ps
`default_nettype none
module pin_device_model
#(
	parameter int NPINS = 16
)
(
	// Clock
	input wire logic clk,
	// Tester side
	input wire logic [NPINS-1:0] pin_drive,
	input wire logic [NPINS-1:0] pin_drive_en,
	output logic [NPINS-1:0] pin_sense,
	output logic dut_sync,
	// Behaviour controls
	input wire logic fault,
	input wire logic slow,
	input wire logic sync_on
);
	logic [NPINS-1:0] dev;
	logic [NPINS-1:0] late;
	logic [3:0] div = 4'h0;
	// Buffer device: each odd pin repeats the even pin below it, inverted while fault is set; released even lines show their own drive inverted
	always_comb
	begin
		for (int p = 0; p < NPINS; p++)
			dev[p] = p % 2 ? pin_drive[p-1] ^ fault : ~pin_drive[p];
	end
	always @(posedge clk)
		late <= dev;
	assign pin_sense = pin_drive_en & pin_drive | ~pin_drive_en & (slow ? late : dev);
	// Self-timed pacing, one period every ten clocks, silent when off
	always @(posedge clk)
		div <= (!sync_on || div == 4'h9) ? 4'h0 : div + 4'h1;
	assign dut_sync = div > 4'h4;
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	localparam int NPINS = 16;
	logic clk = 1'h0, rst_b = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, dut_sync;
	logic fault = 1'h0, slow = 1'h0, sync_on = 1'h0, test_running, test_failed, test_done;
	logic [7:0] reg_addr = 8'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, level_pair_sel;
	logic [5:0] tg_pulse = 6'h0;
	logic [3:0] tg_cnt = 4'h0;
	logic [15:0] pin_sense, pin_drive, pin_drive_en, strobe_line_choice, drive_format_bits, relay_on;
	logic [47:0] timing_gen_choice;
	logic [15:0] q[$];
	logic [15:0] w[4] = '{16'h0303, 16'h0C0C, 16'h3030, 16'hC0C0};
	logic [7:0] ca[12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30};
	logic [31:0] cv[12] = '{32'h2AAA, 32'h5555, 32'h0, 32'hFFFF, 32'hE4E41B1B, 32'hF0, 32'hF0F, 32'h4000,
		32'hFFFF, 32'h0, 32'h0, 32'hA5A5};
	int err_count;
	int n_tests;
	tester_pin_channel_control #(.NPINS(NPINS), .DEPTH(64)) i_dut (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .tg_pulse, .dut_sync, .pin_sense, .pin_drive, .pin_drive_en, .level_pair_sel,
		.strobe_line_choice, .drive_format_bits, .relay_on, .timing_gen_choice, .test_running, .test_failed, .test_done);
	pin_device_model #(.NPINS(NPINS)) i_dev (.clk, .pin_drive, .pin_drive_en, .pin_sense, .dut_sync, .fault, .slow,
		.sync_on);
	always #10 clk = ~clk;
	// Strobe late in each ten-clock period so the three-flop sense path has settled
	always @(posedge clk)
	begin
		tg_cnt <= (reg_wr && reg_addr == 8'h3C || tg_cnt == 4'h9) ? 4'h0 : tg_cnt + 4'h1;
		// No strobe in the start cycle, where nothing has been driven yet
		tg_pulse <= {5'h0, tg_cnt == 4'h7 && !(reg_wr && reg_addr == 8'h3C)};
	end
	task automatic chk(input string s, input logic [47:0] e, input logic [47:0] g);
		n_tests++;
		if (g !== e)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic acc(input logic [7:0] a, input logic [31:0] d, input logic r);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= !r;
		reg_rd <= r;
		@(posedge clk);
		reg_wr <= 1'h0;
		reg_rd <= 1'h0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		acc(a, d, 1'h0);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		acc(a, 32'h0, 1'h1);
		chk($sformatf("reg %h", a), e, reg_rdata);
	endtask
	task automatic run(input logic [31:0] c);
		logic [15:0] prev;
		prev = pin_drive;
		q.delete();
		wr(8'h3C, c);
		repeat (400)
		begin
			@(posedge clk);
			if (pin_drive !== prev)
				q.push_back(pin_drive);
			prev = pin_drive;
			if (!test_running)
				break;
		end
	endtask
	task automatic seqchk();
		int ord[12] = '{0, 1, 2, 1, 2, 3, 0, 1, 2, 1, 2, 3};
		chk("ticks", 48'hC, q.size());
		foreach (ord[i])
			chk("drive", w[ord[i]] ^ 16'h4000, q[i]);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		rst_b <= 1'h1;
		@(posedge clk);
		for (int i = 0; i <= 'h60; i += 4)
			rchk(8'(i), i == 'h5C ? 32'h5 : 32'h0);
		foreach (ca[i])
			wr(ca[i], cv[i]);
		foreach (ca[i])
			rchk(ca[i], cv[i]);
		rchk(8'h34, 32'h0);
		chk("level", 48'hE4E41B1B, level_pair_sel);
		chk("strobe", 48'hF0, strobe_line_choice);
		chk("format", 48'hF0F, drive_format_bits);
		chk("relay", 48'hA5A5, relay_on);
		chk("tg", 48'h00000000FFFF, timing_gen_choice);
		foreach (w[i])
			wr(8'h34, {16'h0, w[i]});
		wr(8'h44, 32'h3);
		wr(8'h48, 32'h1);
		wr(8'h4C, 32'h1);
		wr(8'h50, 32'h2);
		wr(8'h54, 32'h1);
		wr(8'h5C, 32'h1);
		rchk(8'h5C, 32'h5);
		wr(8'h5C, 32'hA);
		// Pin 15 echoes the flipped pin 14 wrongly, but it is masked out
		run(32'h1);
		seqchk();
		chk("enable", 48'h5555, pin_drive_en);
		chk("state", 48'h1, {test_running, test_failed, test_done});
		fault <= 1'h1;
		run(32'h1);
		chk("state", 48'h2, {test_running, test_failed, test_done});
		rchk(8'h1C, 32'h2AAA);
		wr(8'h1C, 32'hFFFF);
		rchk(8'h1C, 32'h0);
		slow <= 1'h1;
		run(32'h5);
		chk("enable", 48'hFFFF, pin_drive_en);
		chk("state", 48'h1, {test_running, test_failed, test_done});
		rchk(8'h3C, 32'h4);
		sync_on <= 1'h1;
		run(32'hD);
		seqchk();
		chk("state", 48'h1, {test_running, test_failed, test_done});
		sync_on <= 1'h0;
		fault <= 1'h0;
		wr(8'h3C, 32'h1);
		// Reload word one while the sequence still runs on word zero
		wr(8'h38, 32'h1);
		wr(8'h34, 32'hF0F);
		repeat (10) @(posedge clk);
		chk("reload", 48'h4F0F, pin_drive);
		chk("state", 48'h4, {test_running, test_failed, test_done});
		wr(8'h3C, 32'h2);
		chk("state", 48'h0, {test_running, test_failed, test_done});
		wrap_up();
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		err_count++;
		wrap_up();
	end
endmodule
bind tester_pin_channel_control pin_channel_monitor #(.NPINS(NPINS)) i_mon (.clk, .rst_b, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .pin_drive, .level_pair_sel, .strobe_line_choice, .drive_format_bits, .relay_on,
	.test_running, .test_failed, .test_done);
`default_nettype wire
